// file: hw/ucl_pkg.sv
/*
  constants for the serial channel control block: register addresses,
  field positions, reset values, interrupt codes and timing.
  assumes a 3-bit register address and 8-bit host data bus.
*/
// Operation
// - fifos on, enables clear: polled mode
// - status shows data ready, tx empties
// - status bit 7: errored char in fifo
// - receive interrupt on data or trigger
// - transmit interrupt when tx fifo empties
// - line errors interrupt; tagged at readout
// - modem delta bits raise modem interrupt
// - timeout after four chars plus twelve bits
// - prioritised four-bit source code
// - report only highest pending source
// - status bit 0 low when pending
// - status bits 7:6 mirror fifo enable
// - line/modem status reads clear interrupts
// - receive interrupts clear by reading
// - tx interrupt cleared by status read or data write
// - fifo control bits 1-7 ignored without bit 0
// - fifo reset bits clear pointers, self-clear
// - bit 3 selects dma pin mode
// - trigger levels 1, 4, 8, 14
// - word length 5 to 8 bits
// - stop length one, one and a half, or two
// - parity enable and odd/even select
// - stick parity forced mark or space
// - break holds transmit line low
// - bit 7 selects divisor latches
package ucl_pkg;
  // ==========================================
  // register addresses
  localparam logic [2:0] UCL_A_DATA  = 3'h0;
  localparam logic [2:0] UCL_A_IEN   = 3'h1;
  localparam logic [2:0] UCL_A_ISTAT = 3'h2;
  localparam logic [2:0] UCL_A_LCTL  = 3'h3;
  localparam logic [2:0] UCL_A_LSTAT = 3'h5;
  localparam logic [2:0] UCL_A_MSTAT = 3'h6;
  // ==========================================
  // field positions
  localparam int UCL_F_FEN  = 0;
  localparam int UCL_F_RRST = 1;
  localparam int UCL_F_TRST = 2;
  localparam int UCL_F_DMA  = 3;
  localparam int UCL_F_TRG  = 6;
  localparam int UCL_L_STOP = 2;
  localparam int UCL_L_PEN  = 3;
  localparam int UCL_L_EVEN = 4;
  localparam int UCL_L_STK  = 5;
  localparam int UCL_L_BRK  = 6;
  localparam int UCL_L_DLAB = 7;
  // ==========================================
  // reset values
  localparam logic [7:0] UCL_IEN_RST  = 8'h00;
  localparam logic [7:0] UCL_LCTL_RST = 8'h00;
  localparam logic [7:0] UCL_DIV_RST  = 8'h01;
  // ==========================================
  // interrupt source codes, bits 3:0
  localparam logic [3:0] UCL_I_LINE = 4'h6;
  localparam logic [3:0] UCL_I_TOUT = 4'hC;
  localparam logic [3:0] UCL_I_RXD  = 4'h4;
  localparam logic [3:0] UCL_I_TXR  = 4'h2;
  localparam logic [3:0] UCL_I_MDM  = 4'h0;
  localparam logic [3:0] UCL_I_NONE = 4'h1;
  // ==========================================
  // timeout: four characters plus twelve bits
  localparam int UCL_TO_CHARS = 4;
  localparam int UCL_TO_BITS  = 12;
  // trigger level per select code
  function automatic logic [4:0] ucl_trig(input logic [1:0] sel);
    case (sel)
      2'h0:    ucl_trig = 5'h01;
      2'h1:    ucl_trig = 5'h04;
      2'h2:    ucl_trig = 5'h08;
      default: ucl_trig = 5'h0E;
    endcase
  endfunction
  // bits per frame: start, data, parity, stop (two stops for 1.5)
  function automatic logic [3:0] ucl_frame(input logic [7:0] lc);
    ucl_frame = 4'h7 + {2'h0, lc[1:0]} + {3'h0, lc[UCL_L_PEN]} + {3'h0, lc[UCL_L_STOP]};
  endfunction
endpackage

// file: hw/ucl_fifo_if.sv
/*
  interface carrying one fifo's write, read and status signals.
  assumes one clock shared by both ends.
*/
`timescale 1ns/1ns
interface ucl_fifo_if #(parameter int W = 11, parameter int DW = 5);
  logic          wr_valid;
  logic          wr_ready;
  logic [W-1:0]  wr_data;
  logic          rd_valid;
  logic          rd_ready;
  logic [W-1:0]  rd_data;
  logic          clear;
  logic [DW-1:0] level;
  modport owner (input wr_valid, wr_data, rd_ready, clear,
                 output wr_ready, rd_valid, rd_data, level);
  modport user  (output wr_valid, wr_data, rd_ready, clear,
                 input wr_ready, rd_valid, rd_data, level);
endinterface

// file: hw/ucl_fifo.sv
/*
  small fifo with valid/ready on both sides and read data taken straight from the head entry.
  assumes clear and push never need to coexist; clear wins.
*/
`timescale 1ns/1ns
module ucl_fifo #(
  parameter int W  = 11,
  parameter int D  = 16,
  parameter int DW = 5
) (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic srst_in,
  // fifo port
  ucl_fifo_if.owner f
);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [DW-1:0]       wp;
    logic [DW-1:0]       rp;
    logic [DW-1:0]       cnt;
  } ucl_fs_t;
  ucl_fs_t s_q, s_d;
  logic push, pop;
  assign push = f.wr_valid && f.wr_ready;
  assign pop  = f.rd_valid && f.rd_ready;
  assign f.wr_ready = (s_q.cnt != DW'(D));
  assign f.rd_valid = (s_q.cnt != '0);
  assign f.rd_data  = s_q.mem[s_q.rp[$clog2(D)-1:0]];
  assign f.level    = s_q.cnt;
  // pointer and count update; a clear drops pointers and count, not the data
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp[$clog2(D)-1:0]] = f.wr_data;
      s_d.wp = (s_q.wp == DW'(D-1)) ? '0 : s_q.wp + 1'b1;
    end
    if (pop) begin
      s_d.rp = (s_q.rp == DW'(D-1)) ? '0 : s_q.rp + 1'b1;
    end
    s_d.cnt = s_q.cnt + DW'(push) - DW'(pop);
    if (f.clear) begin
      s_d.wp  = '0;
      s_d.rp  = '0;
      s_d.cnt = '0;
    end
  end
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// file: hw/ucl_ctrl.sv
/*
  control and status for one serial channel: enables, interrupt
  identification, fifo control, line format, line and modem status.
  assumes the receive shifter delivers characters with error tags and
  the transmit shifter pulls words; the serial engines sit outside.
*/
`timescale 1ns/1ns
module ucl_ctrl #(
  parameter int DEPTH   = 16,
  parameter int CLK_MHZ = 25
) (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  // host register port
  input  wire logic [2:0] addr_in,
  input  wire logic       rd_in,
  input  wire logic       wr_in,
  input  wire logic [7:0] wdata_in,
  output logic      [7:0] rdata_out,
  // receive shifter side
  input  wire logic       rx_valid_in,
  input  wire logic [7:0] rx_char_in,
  input  wire logic [2:0] rx_err_in,
  output logic            rx_ready_out,
  input  wire logic       bit_tick_in,
  // transmit shifter side
  output logic            tx_valid_out,
  output logic      [7:0] tx_char_out,
  input  wire logic       tx_ready_in,
  input  wire logic       tsr_busy_in,
  output logic      [7:0] line_ctl_out,
  output logic            tx_break_out,
  // modem deltas and pins
  input  wire logic [3:0] modem_delta_in,
  input  wire logic [3:0] modem_level_in,
  output logic            irq_out,
  output logic            tx_ready_pin_n_out,
  output logic            rx_ready_pin_n_out
);
  import ucl_pkg::*;
  localparam int DW = $clog2(DEPTH) + 1;

  // ==========================================
  // state
  typedef struct packed {
    logic [7:0] ien;
    logic [7:0] lctl;
    logic       fen;
    logic       dma;
    logic [1:0] trg;
    logic [7:0] dll;
    logic [7:0] divisor_high_latch;
    logic       ovr;
    logic       lerr;
    logic [3:0] mdelta;
    logic       txr;
    logic       tout;
    logic [9:0] tcnt;
    logic       tx_emp_q;
    logic [DW-1:0] errs;
    logic [7:0] rdata;
    logic       irq;
    logic       txpin_n;
    logic       rxpin_n;
    logic       brk;
    logic       txv;
    logic [7:0] txc;
  } ucl_st_t;
  ucl_st_t s_q, s_d;

  ucl_fifo_if #(.W(11), .DW(DW)) rxf ();
  ucl_fifo_if #(.W(8),  .DW(DW)) txf ();

  ucl_fifo #(.W(11), .D(DEPTH), .DW(DW)) u_rx (
    .clk_in  (clk_in),
    .srst_in (srst_in),
    .f       (rxf)
  );
  ucl_fifo #(.W(8), .D(DEPTH), .DW(DW)) u_tx (
    .clk_in  (clk_in),
    .srst_in (srst_in),
    .f       (txf)
  );

  // ==========================================
  // decode
  logic rd_data, wr_data, rd_istat, rd_lstat, rd_mstat, wr_fctl;
  logic dlab, tx_emp, rx_has, trig_hit, pop_err, fctl_ok;
  logic [7:0] lstat, istat;
  logic [3:0] code;
  logic [9:0] to_len;
  assign dlab     = s_q.lctl[UCL_L_DLAB];
  assign rd_data  = rd_in && addr_in == UCL_A_DATA && !dlab;
  assign wr_data  = wr_in && addr_in == UCL_A_DATA && !dlab;
  assign rd_istat = rd_in && addr_in == UCL_A_ISTAT;
  assign rd_lstat = rd_in && addr_in == UCL_A_LSTAT;
  assign rd_mstat = rd_in && addr_in == UCL_A_MSTAT;
  assign wr_fctl  = wr_in && addr_in == UCL_A_ISTAT;
  assign fctl_ok  = wr_fctl && wdata_in[UCL_F_FEN];
  // fifo plumbing; without fifos the receive queue acts one deep
  assign rxf.wr_valid = rx_valid_in && (s_q.fen || rxf.level == '0);
  assign rxf.wr_data  = {rx_err_in, rx_char_in};
  assign rxf.rd_ready = rd_data;
  assign rxf.clear    = fctl_ok && wdata_in[UCL_F_RRST];
  assign txf.wr_valid = wr_data;
  assign txf.wr_data  = wdata_in;
  assign txf.rd_ready = tx_ready_in && !s_q.txv;
  assign txf.clear    = fctl_ok && wdata_in[UCL_F_TRST];
  assign rx_ready_out = 1'b1;
  assign tx_emp   = txf.level == '0;
  assign rx_has   = rxf.level != '0;
  assign trig_hit = s_q.fen ? (rxf.level >= DW'(ucl_trig(s_q.trg))) : rx_has;
  assign pop_err  = rxf.rd_valid && rd_data && rxf.rd_data[10:8] != 3'h0;
  // timeout in bit ticks: four frames plus twelve bits
  assign to_len = 10'(UCL_TO_CHARS) * {6'h0, ucl_frame(s_q.lctl)} + 10'(UCL_TO_BITS);

  // line status word
  always_comb begin
    lstat    = 8'h00;
    lstat[0] = rx_has;
    lstat[1] = s_q.ovr;
    lstat[4:2] = rxf.rd_valid ? rxf.rd_data[10:8] : 3'h0;
    lstat[5] = tx_emp && !s_q.txv;
    lstat[6] = tx_emp && !s_q.txv && !tsr_busy_in;
    lstat[7] = s_q.errs != '0;
  end

  // priority encoder; only the top source is reported
  always_comb begin
    if (s_q.ien[2] && s_q.lerr) begin
      code = UCL_I_LINE;
    end else if (s_q.ien[0] && s_q.tout) begin
      code = UCL_I_TOUT;
    end else if (s_q.ien[0] && trig_hit) begin
      code = UCL_I_RXD;
    end else if (s_q.ien[1] && s_q.txr) begin
      code = UCL_I_TXR;
    end else if (s_q.ien[3] && s_q.mdelta != 4'h0) begin
      code = UCL_I_MDM;
    end else begin
      code = UCL_I_NONE;
    end
    istat = {s_q.fen, s_q.fen, 2'h0, code};
  end

  // ==========================================
  // next state
  always_comb begin
    s_d = s_q;
    s_d.tx_emp_q = tx_emp;
    // host writes
    if (wr_in) begin
      case (addr_in)
        UCL_A_DATA: if (dlab) s_d.dll = wdata_in;
        UCL_A_IEN: begin
          if (dlab) s_d.divisor_high_latch = wdata_in;
          else s_d.ien = {4'h0, wdata_in[3:0]};
        end
        UCL_A_LCTL: s_d.lctl = wdata_in;
        default: ;
      endcase
    end
    if (wr_fctl) begin
      s_d.fen = wdata_in[UCL_F_FEN];
      if (fctl_ok) begin
        s_d.dma = wdata_in[UCL_F_DMA];
        s_d.trg = wdata_in[UCL_F_TRG +: 2];
      end
    end
    // error tag count in the receive queue
    s_d.errs = s_q.errs + DW'(rxf.wr_valid && rxf.wr_ready && rx_err_in != 3'h0)
               - DW'(pop_err);
    if (rxf.clear) s_d.errs = '0;
    // clears first so a same-cycle event wins
    if (rd_lstat) begin
      s_d.ovr  = 1'b0;
      s_d.lerr = 1'b0;
    end
    if (rd_mstat) s_d.mdelta = 4'h0;
    if (rd_istat && code == UCL_I_TXR) s_d.txr = 1'b0;
    if (wr_data) s_d.txr = 1'b0;
    if (rd_data) s_d.tout = 1'b0;
    // events
    if (rx_valid_in && !(rxf.wr_valid && rxf.wr_ready)) begin
      s_d.ovr  = 1'b1;
      s_d.lerr = 1'b1;
    end
    if (pop_err) s_d.lerr = 1'b1;
    s_d.mdelta = s_d.mdelta | modem_delta_in;
    if (tx_emp && !s_q.tx_emp_q) s_d.txr = 1'b1;
    // timeout timer
    if (!rx_has || rd_data || (rxf.wr_valid && rxf.wr_ready)) begin
      s_d.tcnt = 10'h000;
    end else if (bit_tick_in && !s_q.tout) begin
      if (s_q.tcnt + 10'h001 >= to_len) s_d.tout = s_q.fen;
      s_d.tcnt = s_q.tcnt + 10'h001;
    end
    // transmit output stage; stalls keep the word
    if (tx_ready_in && s_q.txv) s_d.txv = 1'b0;
    if (txf.rd_valid && txf.rd_ready) begin
      s_d.txv = 1'b1;
      s_d.txc = txf.rd_data;
    end
    // registered read data
    case (addr_in)
      UCL_A_DATA:  s_d.rdata = dlab ? s_q.dll : rxf.rd_data[7:0];
      UCL_A_IEN:   s_d.rdata = dlab ? s_q.divisor_high_latch : s_q.ien;
      UCL_A_ISTAT: s_d.rdata = istat;
      UCL_A_LCTL:  s_d.rdata = s_q.lctl;
      UCL_A_LSTAT: s_d.rdata = lstat;
      UCL_A_MSTAT: s_d.rdata = {~modem_level_in, s_q.mdelta};
      default:     s_d.rdata = 8'h00;
    endcase
    s_d.irq = code != UCL_I_NONE;
    s_d.brk = s_q.lctl[UCL_L_BRK];
    // dma pins: mode 0 single char, mode 1 block
    s_d.rxpin_n = s_q.dma ? !trig_hit : !rx_has;
    s_d.txpin_n = s_q.dma ? (txf.level == DW'(DEPTH)) : !tx_emp;
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s_q         <= '0;
      s_q.ien     <= UCL_IEN_RST;
      s_q.lctl    <= UCL_LCTL_RST;
      s_q.dll     <= UCL_DIV_RST;
      s_q.tx_emp_q <= 1'b1;
      s_q.rxpin_n <= 1'b1;
      s_q.rdata   <= 8'h00;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================
  // outputs, all registered
  assign rdata_out          = s_q.rdata;
  assign irq_out            = s_q.irq;
  assign tx_break_out       = s_q.brk;
  assign line_ctl_out       = s_q.lctl;
  assign tx_valid_out       = s_q.txv;
  assign tx_char_out        = s_q.txc;
  assign tx_ready_pin_n_out = s_q.txpin_n;
  assign rx_ready_pin_n_out = s_q.rxpin_n;

  // ==========================================
  // checks
  property p_isr_fen;
    @(posedge clk_in) disable iff (srst_in)
      rd_istat |=> rdata_out[7:6] == {2{$past(s_q.fen)}};
  endproperty
  a_isr_fen: assert property (p_isr_fen) else $error("fifo enable bits wrong");
  property p_none;
    @(posedge clk_in) disable iff (srst_in)
      (rd_istat && s_q.ien[3:0] == 4'h0) |=> rdata_out[3:0] == UCL_I_NONE;
  endproperty
  a_none: assert property (p_none) else $error("polled mode reports source");
  property p_lsr_clr;
    @(posedge clk_in) disable iff (srst_in)
      (rd_lstat && !rx_valid_in && !pop_err) |=> !s_q.lerr;
  endproperty
  a_lsr_clr: assert property (p_lsr_clr) else $error("line irq not cleared");
  property p_brk;
    @(posedge clk_in) disable iff (srst_in)
      s_q.lctl[UCL_L_BRK] |=> tx_break_out;
  endproperty
  a_brk: assert property (p_brk) else $error("break not held");
  property p_temt;
    @(posedge clk_in) disable iff (srst_in)
      (rd_lstat && tsr_busy_in) |=> !rdata_out[6];
  endproperty
  a_temt: assert property (p_temt) else $error("shift empty wrong");
  property p_fcr_gate;
    @(posedge clk_in) disable iff (srst_in)
      (wr_fctl && !wdata_in[UCL_F_FEN]) |=> $stable(s_q.trg) && $stable(s_q.dma);
  endproperty
  a_fcr_gate: assert property (p_fcr_gate) else $error("fifo ctl taken without enable");
  property p_rclr;
    @(posedge clk_in) disable iff (srst_in)
      rxf.clear |=> rxf.level == '0;
  endproperty
  a_rclr: assert property (p_rclr) else $error("rx fifo not reset");
  property p_tout_clr;
    @(posedge clk_in) disable iff (srst_in)
      rd_data |=> !s_q.tout;
  endproperty
  a_tout_clr: assert property (p_tout_clr) else $error("timeout not cleared");
endmodule

// file: verif/ucl_tx_sink.sv
/*
  stand-in for the transmit shifter: takes one word, then shifts it
  out for HOLD cycles with the shift register reported busy.
  assumes the block holds its word until tx_ready is seen high.
*/
`timescale 1ns/1ns
module ucl_tx_sink #(
  parameter int HOLD = 60
) (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  // word from the block
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_char_in,
  output logic            tx_ready_out,
  output logic            tsr_busy_out,
  output logic      [7:0] last_char_out
);
  // ==========================================
  // shift timer
  int cnt_q;
  // one word at a time, so a slow line really stalls the block
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cnt_q <= 0;
    end else if (tx_valid_in && tx_ready_out) begin
      cnt_q         <= HOLD;
      last_char_out <= tx_char_in;
    end else if (cnt_q > 0) begin
      cnt_q <= cnt_q - 1;
    end
  end
  // ready only when idle; busy while the word shifts out
  assign tx_ready_out = (cnt_q == 0) && !srst_in;
  assign tsr_busy_out = (cnt_q != 0);
endmodule

// file: verif/test_ucl_ctrl.sv
/*
  self-checking bench for the channel control block: register
  traffic, received characters, interrupt codes and pins.
  assumes the design package and the transmit shifter stand-in.
*/
`timescale 1ns/1ns
module test_ucl_ctrl;
  import ucl_pkg::*;
  // ==========================================
  // stimulus and observed signals
  logic       clk_in, srst_in, rd_in, wr_in, rx_valid_in, bit_tick_in;
  logic [2:0] addr_in, rx_err_in;
  logic [7:0] wdata_in, rx_char_in, rdata_out, tx_char_out, line_ctl_out, last_char;
  logic [3:0] modem_delta_in, modem_level_in;
  logic       tx_valid_out, tx_ready_in, tsr_busy_in, tx_break_out, irq_out;
  logic       tx_pin_n, rx_pin_n;
  int         n_fail, samples_checked, seed;

  ucl_ctrl #(.DEPTH(16), .CLK_MHZ(25)) dut_u (
    .clk_in(clk_in), .srst_in(srst_in), .addr_in(addr_in), .rd_in(rd_in),
    .wr_in(wr_in), .wdata_in(wdata_in), .rdata_out(rdata_out),
    .rx_valid_in(rx_valid_in), .rx_char_in(rx_char_in), .rx_err_in(rx_err_in),
    .rx_ready_out(), .bit_tick_in(bit_tick_in), .tx_valid_out(tx_valid_out),
    .tx_char_out(tx_char_out), .tx_ready_in(tx_ready_in), .tsr_busy_in(tsr_busy_in),
    .line_ctl_out(line_ctl_out), .tx_break_out(tx_break_out),
    .modem_delta_in(modem_delta_in), .modem_level_in(modem_level_in),
    .irq_out(irq_out), .tx_ready_pin_n_out(tx_pin_n), .rx_ready_pin_n_out(rx_pin_n));

  ucl_tx_sink #(.HOLD(60)) sink_u (
    .clk_in(clk_in), .srst_in(srst_in), .tx_valid_in(tx_valid_out),
    .tx_char_in(tx_char_out), .tx_ready_out(tx_ready_in),
    .tsr_busy_out(tsr_busy_in), .last_char_out(last_char));

  // ==========================================
  // clock, 40 ns period
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // ==========================================
  // expectations
  function automatic int lvl(input int sel);
    return (sel == 0) ? 1 : (sel == 1) ? 4 : (sel == 2) ? 8 : 14;
  endfunction
  // status byte: fifo flags on top, source code below
  function automatic logic [7:0] interrupt_status(input logic fon, input logic [3:0] c);
    return {fon, fon, 2'h0, c};
  endfunction
  // four frames (start, data, parity, stop) plus twelve bit times
  function automatic int tout(input logic [7:0] lc);
    return 4 * (7 + lc[1:0] + lc[3] + lc[2]) + 12;
  endfunction

  // ==========================================
  // compares and bus tasks
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // strobes rise and fall at falling edges, taken at the rising edge
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr_in  = a;
    wdata_in = d;
    wr_in    = 1'b1;
    @(negedge clk_in);
    wr_in = 1'b0;
  endtask
  // read data is registered, so it is picked up half a cycle later
  task automatic rreg(input logic [2:0] a, output logic [7:0] d);
    @(negedge clk_in);
    addr_in = a;
    rd_in   = 1'b1;
    @(negedge clk_in);
    rd_in = 1'b0;
    d     = rdata_out;
  endtask
  task automatic rchk(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    rreg(a, d);
    chk8(d, e);
  endtask
  task automatic push(input logic [7:0] c, input logic [2:0] e);
    @(negedge clk_in);
    rx_char_in  = c;
    rx_err_in   = e;
    rx_valid_in = 1'b1;
    @(negedge clk_in);
    rx_valid_in = 1'b0;
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(negedge clk_in);
      bit_tick_in = 1'b1;
      @(negedge clk_in);
      bit_tick_in = 1'b0;
    end
  endtask
  task automatic rst();
    @(negedge clk_in);
    srst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    srst_in = 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========================================
  // watchdog, far beyond the fewer than one thousand cycles the tests need
  initial begin
    #800000;
    n_fail++;
    tally_and_finish();
  end

  // ==========================================
  // test sequence
  initial begin
    logic [7:0] v;
    logic [7:0] d;
    int         n;
    seed            = 54;
    n_fail          = 0;
    samples_checked = 0;
    {rd_in, wr_in, rx_valid_in, bit_tick_in} = 4'h0;
    {addr_in, rx_err_in} = 6'h00;
    {wdata_in, rx_char_in} = 16'h0000;
    modem_delta_in  = 4'h0;
    modem_level_in  = 4'hF;
    srst_in         = 1'b1;
    repeat (2) @(negedge clk_in);
    srst_in = 1'b0;
    // reset values, then line format with random values and one corner
    rchk(UCL_A_IEN, UCL_IEN_RST);
    rchk(UCL_A_ISTAT, interrupt_status(1'b0, UCL_I_NONE));
    rchk(UCL_A_LSTAT, 8'h60);
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 8'h7F : 8'($random(seed)) & 8'h7F;
      wreg(UCL_A_LCTL, v);
      rchk(UCL_A_LCTL, v);
      chk8(line_ctl_out, v);
      chk1(tx_break_out, v[6]);
    end
    wreg(UCL_A_LCTL, 8'h80);
    wreg(UCL_A_IEN, 8'hA5);
    rchk(UCL_A_IEN, 8'hA5);
    rchk(UCL_A_DATA, UCL_DIV_RST);
    wreg(UCL_A_LCTL, 8'h00);
    wreg(UCL_A_IEN, 8'hFF);
    rchk(UCL_A_IEN, 8'h0F);
    wreg(UCL_A_ISTAT, 8'hC1);
    rchk(UCL_A_ISTAT, interrupt_status(1'b1, UCL_I_NONE));
    wreg(UCL_A_ISTAT, 8'hC6);
    rchk(UCL_A_ISTAT, interrupt_status(1'b0, UCL_I_NONE));
    $display("test registers done");
    // each trigger level: one short of it, then reaching it
    for (int s = 0; s < 4; s++) begin
      rst();
      wreg(UCL_A_ISTAT, {2'(s), 6'h01});
      for (int k = 1; k < lvl(s); k++) push(8'(k), 3'h0);
      rchk(UCL_A_LSTAT, {7'h30, lvl(s) > 1});
      chk1(irq_out, 1'b0);
      chk1(rx_pin_n, lvl(s) == 1);
      wreg(UCL_A_IEN, 8'h01);
      rchk(UCL_A_ISTAT, interrupt_status(1'b1, UCL_I_NONE));
      push(8'hEE, 3'h0);
      rchk(UCL_A_ISTAT, interrupt_status(1'b1, UCL_I_RXD));
      chk1(irq_out, 1'b1);
      rchk(UCL_A_DATA, (lvl(s) > 1) ? 8'h01 : 8'hEE);
      rchk(UCL_A_ISTAT, interrupt_status(1'b1, UCL_I_NONE));
      wreg(UCL_A_ISTAT, {2'(s), 6'h03});
      rchk(UCL_A_LSTAT, 8'h60);
      push(8'h5C, 3'h0);
      rchk(UCL_A_LSTAT, 8'h61);
    end
    rst();
    wreg(UCL_A_IEN, 8'h01);
    push(8'h55, 3'h0);
    rchk(UCL_A_ISTAT, interrupt_status(1'b0, UCL_I_RXD));
    rchk(UCL_A_DATA, 8'h55);
    $display("test trigger levels done");
    // receive timeout, restarted by a second character
    rst();
    wreg(UCL_A_LCTL, 8'h03);
    wreg(UCL_A_ISTAT, 8'h41);
    wreg(UCL_A_IEN, 8'h01);
    n = tout(8'h03);
    push(8'hA1, 3'h0);
    ticks(n - 12);
    push(8'hB2, 3'h0);
    ticks(n - 2);
    rchk(UCL_A_ISTAT, interrupt_status(1'b1, UCL_I_NONE));
    ticks(4);
    rchk(UCL_A_ISTAT, interrupt_status(1'b1, UCL_I_TOUT));
    rchk(UCL_A_DATA, 8'hA1);
    rchk(UCL_A_ISTAT, interrupt_status(1'b1, UCL_I_NONE));
    $display("test timeout done");
    // errored character, then overrun of a full queue
    rst();
    wreg(UCL_A_ISTAT, 8'hC1);
    wreg(UCL_A_IEN, 8'h04);
    push(8'h11, 3'h1);
    rreg(UCL_A_LSTAT, d);
    chk1(d[7], 1'b1);
    for (int k = 0; k < 16; k++) push(8'(k), 3'h0);
    rchk(UCL_A_ISTAT, interrupt_status(1'b1, UCL_I_LINE));
    rreg(UCL_A_LSTAT, d);
    chk1(d[1], 1'b1);
    rchk(UCL_A_ISTAT, interrupt_status(1'b1, UCL_I_NONE));
    rchk(UCL_A_DATA, 8'h11);
    rchk(UCL_A_ISTAT, interrupt_status(1'b1, UCL_I_LINE));
    rreg(UCL_A_LSTAT, d);
    chk1(d[7], 1'b0);
    rchk(UCL_A_ISTAT, interrupt_status(1'b1, UCL_I_NONE));
    $display("test line errors done");
    // several sources pending, served one at a time by priority
    rst();
    wreg(UCL_A_ISTAT, 8'h01);
    wreg(UCL_A_IEN, 8'h0F);
    rreg(UCL_A_ISTAT, d);
    wreg(UCL_A_DATA, 8'h5A);
    repeat (6) @(negedge clk_in);
    rchk(UCL_A_LSTAT, 8'h20);
    modem_level_in = 4'h5;
    modem_delta_in = 4'h4;
    @(negedge clk_in);
    modem_delta_in = 4'h0;
    push(8'h77, 3'h0);
    rchk(UCL_A_ISTAT, interrupt_status(1'b1, UCL_I_RXD));
    chk8(last_char, 8'h5A);
    rchk(UCL_A_DATA, 8'h77);
    rchk(UCL_A_ISTAT, interrupt_status(1'b1, UCL_I_TXR));
    rchk(UCL_A_ISTAT, interrupt_status(1'b1, UCL_I_MDM));
    rchk(UCL_A_MSTAT, {~4'h5, 4'h4});
    rchk(UCL_A_ISTAT, interrupt_status(1'b1, UCL_I_NONE));
    repeat (70) @(negedge clk_in);
    rchk(UCL_A_LSTAT, 8'h60);
    // second word waits behind a busy shifter, so only the write clears
    wreg(UCL_A_DATA, 8'hA6);
    repeat (4) @(negedge clk_in);
    wreg(UCL_A_DATA, 8'h3C);
    rchk(UCL_A_ISTAT, interrupt_status(1'b1, UCL_I_NONE));
    repeat (70) @(negedge clk_in);
    rchk(UCL_A_ISTAT, interrupt_status(1'b1, UCL_I_TXR));
    $display("test priority done");
    // dma pin mode, transmit queue filled until refused, then flushed
    rst();
    wreg(UCL_A_ISTAT, 8'h49);
    chk1(rx_pin_n, 1'b1);
    for (int k = 0; k < 3; k++) push(8'(k), 3'h0);
    chk1(rx_pin_n, 1'b1);
    push(8'h33, 3'h0);
    repeat (2) @(negedge clk_in);
    chk1(rx_pin_n, 1'b0);
    chk1(tx_pin_n, 1'b0);
    for (int k = 0; k < 18; k++) wreg(UCL_A_DATA, 8'($random(seed)));
    repeat (2) @(negedge clk_in);
    chk1(tx_pin_n, 1'b1);
    rreg(UCL_A_LSTAT, d);
    chk1(d[5], 1'b0);
    wreg(UCL_A_ISTAT, 8'h4D);
    repeat (2) @(negedge clk_in);
    chk1(tx_pin_n, 1'b0);
    rreg(UCL_A_LSTAT, d);
    chk1(d[5], 1'b1);
    $display("test dma pins done");
    tally_and_finish();
  end
endmodule
